// ===== hw/ack_ctrl_pkg.sv
// Constants and types shared by the acknowledge-handling serial slave
package ack_ctrl_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int IRQ_W = 4;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h01;
  localparam logic [ADDR_W-1:0] REG_SLAVE_ADDR = 8'h02;
  localparam logic [ADDR_W-1:0] REG_DATA = 8'h03;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h05;
  localparam logic [ADDR_W-1:0] REG_RELEASE = 8'h06;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_ADDR_HOLD = 0;
  localparam int CTRL_DATA_HOLD = 1;
  localparam int CTRL_ACK_VALUE = 2;
  localparam int ST_ACK_RESULT = 0;
  localparam int ST_ACK_TIME = 1;
  localparam int ST_BUF_FULL = 2;
  localparam int ST_OVERFLOW = 3;
  localparam int ST_READ_REQ = 4;
  localparam int ST_CLK_HOLD = 5;
  localparam int IRQ_BYTE = 0;
  localparam int IRQ_ACK_TIME = 1;
  localparam int IRQ_NACK = 2;
  localparam int IRQ_STOP = 3;

  // ----------------------------------------
  // Reset values and counts
  // ----------------------------------------
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] SLAVE_ADDR_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ----------------------------------------
  // Engine states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_RX, ST_ACK_OUT, ST_TX, ST_ACK_IN, ST_WAIT
  } ack_state_t;

endpackage : ack_ctrl_pkg

// ===== hw/bus_sense_if.sv
// Conditioned bus line levels and events passed from the sampler
`timescale 1ns/1ps
interface bus_sense_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport src (output scl, sda, scl_rise, scl_fall, start, stop);
  modport dst (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface : bus_sense_if

// ===== hw/line_sense.sv
// Two-stage sampler and edge/condition detector for the bus lines
`timescale 1ns/1ps
module line_sense (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Raw pins
  input wire logic scl_in,
  input wire logic sda_in,
  // Conditioned view
  bus_sense_if.src sense
);

  logic scl_meta;
  logic sda_meta;
  logic scl_sync;
  logic sda_sync;
  logic scl_prev;
  logic sda_prev;

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      scl_meta <= 1'b1;
      sda_meta <= 1'b1;
      scl_sync <= 1'b1;
      sda_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      sda_meta <= sda_in;
      scl_sync <= scl_meta;
      sda_sync <= sda_meta;
      scl_prev <= scl_sync;
      sda_prev <= sda_sync;
    end
  end

  // ----------------------------------------
  // Events
  // ----------------------------------------
  // Lines idle high, so reset to high avoids a false edge
  assign sense.scl = scl_sync;
  assign sense.sda = sda_sync;
  assign sense.scl_rise = scl_sync && !scl_prev;
  assign sense.scl_fall = !scl_sync && scl_prev;
  assign sense.start = scl_sync && scl_prev && sda_prev && !sda_sync;
  assign sense.stop = scl_sync && scl_prev && !sda_prev && sda_sync;

endmodule : line_sense

// ===== hw/ack_slave.sv
// Serial bus slave with acknowledge generation, clock hold and status
`timescale 1ns/1ps
module ack_slave (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Bus pins, open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  // Register port
  input wire logic [ack_ctrl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ack_ctrl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ack_ctrl_pkg::DATA_W-1:0] reg_rdata,
  // Interrupt
  output logic irq
);
  import ack_ctrl_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  bus_sense_if sense ();

  ack_state_t state;
  logic [3:0] bit_cnt;
  logic [DATA_W-1:0] shift;
  logic [DATA_W-1:0] tx_shift;
  logic rw;
  logic from_addr;
  logic ack_given;
  logic nack_forced;
  logic manual_ack;

  logic [DATA_W-1:0] serial_port_control_two;
  logic [DATA_W-1:0] slave_address_reg;
  logic [DATA_W-1:0] rx_buf;
  logic [DATA_W-1:0] tx_buf;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] events;
  logic [DATA_W-1:0] status_val;
  logic [DATA_W-1:0] next_rdata;

  logic ack_result_flag;
  logic ack_time_flag;
  logic buffer_full_flag;
  logic receive_overflow_flag;

  logic manual;
  logic withhold;
  logic byte_done;
  logic addr_hit;
  logic accept;
  logic ack9_fall;
  logic ack_in_rise;
  logic release_wr;
  logic data_rd;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] off);
    reg_hit = (addr == off);
  endfunction : reg_hit

  // Seven-bit match; the direction bit is left out
  function automatic logic addr_match(input logic [DATA_W-1:0] rx,
                                      input logic [DATA_W-1:0] own);
    addr_match = (rx[7:1] == own[6:0]);
  endfunction : addr_match

  // ----------------------------------------
  // Line sampler
  // ----------------------------------------
  line_sense u_sense (
    .core_clk(core_clk),
    .nrst(nrst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sense(sense)
  );

  // ----------------------------------------
  // Decode of bus events
  // ----------------------------------------
  assign manual = serial_port_control_two[CTRL_ADDR_HOLD] |
                  serial_port_control_two[CTRL_DATA_HOLD];
  assign withhold = buffer_full_flag | receive_overflow_flag;
  assign byte_done = sense.scl_fall && (bit_cnt == BYTE_BITS) &&
                     (state == ST_ADDR || state == ST_RX);
  assign addr_hit = addr_match(shift, slave_address_reg);
  assign accept = byte_done && (state == ST_RX || addr_hit);
  assign ack9_fall = sense.scl_fall && (state == ST_ACK_OUT);
  assign ack_in_rise = sense.scl_rise && (state == ST_ACK_IN);
  assign release_wr = reg_wr && reg_hit(reg_addr, REG_RELEASE);
  assign data_rd = reg_rd && reg_hit(reg_addr, REG_DATA);

  // ----------------------------------------
  // Bus engine
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= DATA_RESET;
      tx_shift <= DATA_RESET;
      rw <= 1'b0;
      from_addr <= 1'b0;
      ack_given <= 1'b0;
      nack_forced <= 1'b0;
      manual_ack <= 1'b0;
      sda_oe <= 1'b0;
    end else if (sense.start) begin
      // Start or repeated start always restarts address phase
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (sense.stop) begin
      state <= ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_RX: begin
          if (sense.scl_rise) begin
            shift <= {shift[6:0], sense.sda};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done) begin
            if (state == ST_ADDR && !addr_hit) begin
              state <= ST_WAIT;
            end else begin
              state <= ST_ACK_OUT;
              from_addr <= (state == ST_ADDR);
              if (state == ST_ADDR) begin
                rw <= shift[0];
              end
              nack_forced <= withhold;
              manual_ack <= manual;
              // Auto answer goes out one cycle after the eighth fall
              sda_oe <= !manual && !withhold;
              ack_given <= !manual && !withhold;
            end
          end
        end
        ST_ACK_OUT: begin
          if (ack9_fall) begin
            bit_cnt <= 4'h0;
            if (!ack_given) begin
              state <= ST_WAIT;
              sda_oe <= 1'b0;
            end else if (from_addr && rw) begin
              state <= ST_TX;
              tx_shift <= tx_buf;
              sda_oe <= !tx_buf[7];
            end else begin
              state <= ST_RX;
              sda_oe <= 1'b0;
            end
          end else if (release_wr && scl_oe && manual_ack) begin
            // Software answer, still refused when the buffer was busy
            sda_oe <= !serial_port_control_two[CTRL_ACK_VALUE] && !nack_forced;
            ack_given <= !serial_port_control_two[CTRL_ACK_VALUE] && !nack_forced;
          end
        end
        ST_TX: begin
          if (sense.scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (sense.scl_fall) begin
            if (bit_cnt == BYTE_BITS) begin
              state <= ST_ACK_IN;
              sda_oe <= 1'b0;
            end else begin
              tx_shift <= {tx_shift[6:0], 1'b0};
              sda_oe <= !tx_shift[6];
            end
          end
        end
        ST_ACK_IN: begin
          if (sense.scl_fall) begin
            bit_cnt <= 4'h0;
            if (!ack_result_flag) begin
              // Next byte reuses whatever software left in the buffer
              state <= ST_TX;
              tx_shift <= tx_buf;
              sda_oe <= !tx_buf[7];
            end else begin
              state <= ST_WAIT;
            end
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Acknowledge result
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_result_flag <= 1'b0;
    end else if (ack_in_rise) begin
      ack_result_flag <= sense.sda;
    end
  end

  // ----------------------------------------
  // Acknowledge time and clock hold
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_time_flag <= 1'b0;
    end else if (accept && manual) begin
      ack_time_flag <= 1'b1;
    end else if (ack9_fall || sense.start || sense.stop || !manual) begin
      ack_time_flag <= 1'b0;
    end
  end

  // Holding SCL low gives software unlimited time to decide
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      scl_oe <= 1'b0;
    end else if (accept && manual) begin
      scl_oe <= 1'b1;
    end else if (release_wr || sense.start || sense.stop) begin
      scl_oe <= 1'b0;
    end
  end

  // Open drain: only the enables move
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // Receive buffer and its flags
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_buf <= DATA_RESET;
    end else if (accept && !buffer_full_flag) begin
      rx_buf <= shift;
    end
  end

  // Fill wins over a read in the same cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      buffer_full_flag <= 1'b0;
    end else if (accept && !buffer_full_flag) begin
      buffer_full_flag <= 1'b1;
    end else if (data_rd) begin
      buffer_full_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      receive_overflow_flag <= 1'b0;
    end else if (accept && buffer_full_flag) begin
      receive_overflow_flag <= 1'b1;
    end else if (reg_wr && reg_hit(reg_addr, REG_STATUS) &&
                 reg_wdata[ST_OVERFLOW]) begin
      receive_overflow_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      serial_port_control_two <= CTRL_RESET;
      slave_address_reg <= SLAVE_ADDR_RESET;
      tx_buf <= DATA_RESET;
      irq_mask <= IRQ_RESET;
    end else if (reg_wr) begin
      if (reg_hit(reg_addr, REG_CTRL)) begin
        serial_port_control_two <= reg_wdata;
      end else if (reg_hit(reg_addr, REG_SLAVE_ADDR)) begin
        slave_address_reg <= reg_wdata;
      end else if (reg_hit(reg_addr, REG_DATA)) begin
        tx_buf <= reg_wdata;
      end else if (reg_hit(reg_addr, REG_IRQ_MASK)) begin
        irq_mask <= reg_wdata[IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  always_comb begin
    events = '0;
    events[IRQ_BYTE] = accept;
    events[IRQ_ACK_TIME] = accept && manual;
    events[IRQ_NACK] = ack_in_rise && sense.sda;
    events[IRQ_STOP] = sense.stop;
  end

  // Write one to clear; a new event in the same cycle survives
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_status <= IRQ_RESET;
    end else if (reg_wr && reg_hit(reg_addr, REG_IRQ_STATUS)) begin
      irq_status <= (irq_status & ~reg_wdata[IRQ_W-1:0]) | events;
    end else begin
      irq_status <= irq_status | events;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb begin
    status_val = '0;
    status_val[ST_ACK_RESULT] = ack_result_flag;
    // Gated so a hold-off write hides the flag in the very next read
    status_val[ST_ACK_TIME] = ack_time_flag && manual;
    status_val[ST_BUF_FULL] = buffer_full_flag;
    status_val[ST_OVERFLOW] = receive_overflow_flag;
    status_val[ST_READ_REQ] = rw;
    status_val[ST_CLK_HOLD] = scl_oe;
  end

  always_comb begin
    next_rdata = '0;
    if (reg_hit(reg_addr, REG_CTRL)) begin
      next_rdata = serial_port_control_two;
    end else if (reg_hit(reg_addr, REG_STATUS)) begin
      next_rdata = status_val;
    end else if (reg_hit(reg_addr, REG_SLAVE_ADDR)) begin
      next_rdata = slave_address_reg;
    end else if (reg_hit(reg_addr, REG_DATA)) begin
      next_rdata = rx_buf;
    end else if (reg_hit(reg_addr, REG_IRQ_STATUS)) begin
      next_rdata = {{(DATA_W-IRQ_W){1'b0}}, irq_status};
    end else if (reg_hit(reg_addr, REG_IRQ_MASK)) begin
      next_rdata = {{(DATA_W-IRQ_W){1'b0}}, irq_mask};
    end
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule : ack_slave

// ===== bench/ack_slave_chk.sv
// Port checker for the acknowledge-handling serial slave
`timescale 1ns/1ps
module ack_slave_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Register port
  input wire logic [ack_ctrl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ack_ctrl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ack_ctrl_pkg::DATA_W-1:0] reg_rdata,
  // Interrupt
  input wire logic irq
);
  import ack_ctrl_pkg::*;
  // ------------------------------
  // Shadow of the control register
  // ------------------------------
  logic [DATA_W-1:0] ctrl_seen;
  logic hold_on;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_seen <= CTRL_RESET;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      ctrl_seen <= reg_wdata;
    end
  end
  assign hold_on = ctrl_seen[CTRL_ADDR_HOLD] || ctrl_seen[CTRL_DATA_HOLD];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ------------------------------
  // Assertions
  // ------------------------------
  open_drain_a: assert property (!scl_out && !sda_out)
    else $error("bus outputs drive a high level");
  // Past level, since a release write lets SCL rise in the very next cycle
  sda_steady_a: assert property ($changed(sda_oe) |-> !$past(scl_in))
    else $error("data line moved while the clock was high");
  hold_release_a: assert property ($fell(scl_oe) |-> $past(reg_wr) && $past(reg_addr) == REG_RELEASE)
    else $error("clock hold ended without a release write");
  ack_choice_a: assert property ($fell(scl_oe) && ctrl_seen[CTRL_ACK_VALUE] |-> !sda_oe)
    else $error("acknowledge sent although software chose a refusal");
  auto_no_hold_a: assert property ($rose(scl_oe) |-> hold_on)
    else $error("clock held with both hold enables clear");
  ack_time_off_a: assert property ($past(reg_rd) && $past(reg_addr) == REG_STATUS &&
    !$past(hold_on) |-> !reg_rdata[ST_ACK_TIME])
    else $error("acknowledge time flag seen with holds off");
  ack_time_on_a: assert property ($past(reg_rd) && $past(reg_addr) == REG_STATUS &&
    $past(scl_oe) |-> reg_rdata[ST_ACK_TIME] && reg_rdata[ST_CLK_HOLD])
    else $error("acknowledge time flag low during clock hold");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");
  mask_quiet_a: assert property (reg_wr && reg_addr == REG_IRQ_MASK && reg_wdata == '0 |-> ##2 !irq)
    else $error("interrupt high with every source masked");
  hold_done_c: cover property ($fell(scl_oe));
  ack_out_c: cover property ($rose(sda_oe));
  irq_up_c: cover property ($rose(irq));
endmodule : ack_slave_chk
bind ack_slave ack_slave_chk ack_slave_chk_inst (
  .core_clk(core_clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq)
);

// ===== bench/link_master_model.sv
// Behavioural bus master driving the serial link from the far side
`timescale 1ns/1ps
module link_master_model (
  // Clock
  input wire logic core_clk,
  // Resolved bus lines
  input wire logic scl_line,
  input wire logic sda_line,
  // Open-drain pulls, high pulls the line low
  output logic scl_pull,
  output logic sda_pull
);
  int stalls = 0;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // ------------------------------
  // One clock pulse, 8 core cycles
  // ------------------------------
  // Data moves one cycle after the fall so the slave never sees a false stop
  task automatic bit_slot(input logic b, output logic r);
    int n;
    @(posedge core_clk);
    sda_pull <= !b;
    repeat (4) @(posedge core_clk);
    scl_pull <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (scl_line !== 1'b1 && n < 400);
    if (n >= 400) stalls++;
    r = sda_line;
    repeat (2) @(posedge core_clk);
    scl_pull <= 1'b1;
  endtask : bit_slot
  task automatic start_cond();
    @(posedge core_clk);
    sda_pull <= 1'b0;
    repeat (5) @(posedge core_clk);
    scl_pull <= 1'b0;
    repeat (4) @(posedge core_clk);
    sda_pull <= 1'b1;
    repeat (4) @(posedge core_clk);
    scl_pull <= 1'b1;
  endtask : start_cond
  task automatic stop_cond();
    @(posedge core_clk);
    sda_pull <= 1'b1;
    repeat (5) @(posedge core_clk);
    scl_pull <= 1'b0;
    repeat (4) @(posedge core_clk);
    sda_pull <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : stop_cond
  task automatic send_byte(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(d[i], r);
    bit_slot(1'b1, nack);
  endtask : send_byte
  task automatic get_byte(input logic nack_out, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
    bit_slot(nack_out, r);
  endtask : get_byte
endmodule : link_master_model

// ===== bench/testbench.sv
// Self-checking testbench for the acknowledge-handling serial slave
`timescale 1ns/1ps
module testbench;
  import ack_ctrl_pkg::*;
  localparam logic [6:0] OWN_ADDR = 7'h2a;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic scl_out, scl_oe, sda_out, sda_oe, irq, m_scl, m_sda;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  wire scl_line;
  wire sda_line;
  int err_count = 0;
  int comparisons = 0;
  // Pulled-up open-drain lines
  assign scl_line = !(scl_oe || m_scl);
  assign sda_line = !(sda_oe || m_sda);
  always #12.5 core_clk = ~core_clk;
  ack_slave ack_slave_inst (.core_clk(core_clk), .nrst(nrst), .scl_in(scl_line),
    .sda_in(sda_line), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
    .sda_oe(sda_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  link_master_model link_master_model_inst (.core_clk(core_clk), .scl_line(scl_line),
    .sda_line(sda_line), .scl_pull(m_scl), .sda_pull(m_sda));
  // ------------------------------
  // Checking and register access
  // ------------------------------
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read
  task automatic expect_reg(input string what, input logic [7:0] a, input logic [7:0] m,
      input logic [7:0] exp);
    logic [7:0] d;
    reg_read(a, d);
    check(what, d & m, exp);
  endtask : expect_reg
  // Byte under clock hold: software answers through the release write
  task automatic held_byte(input logic [7:0] d, input logic exp_nack);
    logic nack;
    int n;
    fork
      link_master_model_inst.send_byte(d, nack);
      begin
        n = 0;
        while (scl_oe !== 1'b1 && n < 200) begin
          @(posedge core_clk);
          n++;
        end
        if (n >= 200) begin
          err_count++;
          close_out();
        end
        expect_reg("held status", REG_STATUS, 8'h22, 8'h22);
        reg_write(REG_RELEASE, 8'h00);
      end
    join
    check("held answer", {7'h0, nack}, {7'h0, exp_nack});
    // Ninth fall reaches the flag only after the two-stage sampler
    repeat (4) @(posedge core_clk);
    expect_reg("flag after slot", REG_STATUS, 8'h22, 8'h00);
  endtask : held_byte
  initial begin
    repeat (100000) @(posedge core_clk);
    err_count++;
    close_out();
  end
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    logic [7:0] d;
    logic nack;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    check("irq reset", {7'h0, irq}, 8'h00);
    expect_reg("ctrl reset", REG_CTRL, 8'hff, CTRL_RESET);
    expect_reg("status reset", REG_STATUS, 8'hff, 8'h00);
    reg_write(8'h07, 8'hff);
    expect_reg("unmapped", 8'h07, 8'hff, 8'h00);
    reg_write(REG_IRQ_MASK, 8'h00);
    reg_write(REG_SLAVE_ADDR, {1'b0, OWN_ADDR});
    // Automatic answers, then a refusal on a full buffer
    link_master_model_inst.start_cond();
    link_master_model_inst.send_byte({OWN_ADDR, 1'b0}, nack);
    check("address ack", {7'h0, nack}, 8'h00);
    expect_reg("rx address", REG_DATA, 8'hff, {OWN_ADDR, 1'b0});
    link_master_model_inst.send_byte(8'h5a, nack);
    check("data ack", {7'h0, nack}, 8'h00);
    link_master_model_inst.send_byte(8'hc3, nack);
    check("full nack", {7'h0, nack}, 8'h01);
    expect_reg("full flags", REG_STATUS, 8'h0e, 8'h0c);
    link_master_model_inst.stop_cond();
    check("irq masked", {7'h0, irq}, 8'h00);
    expect_reg("irq status", REG_IRQ_STATUS, 8'h0f, 8'h09);
    reg_write(REG_IRQ_MASK, 8'h0f);
    repeat (2) @(posedge core_clk);
    check("irq raised", {7'h0, irq}, 8'h01);
    reg_write(REG_IRQ_STATUS, 8'h0f);
    repeat (2) @(posedge core_clk);
    check("irq cleared", {7'h0, irq}, 8'h00);
    expect_reg("kept byte", REG_DATA, 8'hff, 8'h5a);
    reg_write(REG_STATUS, 8'h08);
    expect_reg("flags clear", REG_STATUS, 8'h0c, 8'h00);
    // Foreign address is ignored silently
    link_master_model_inst.start_cond();
    link_master_model_inst.send_byte({OWN_ADDR ^ 7'h01, 1'b0}, nack);
    check("miss nack", {7'h0, nack}, 8'h01);
    link_master_model_inst.stop_cond();
    expect_reg("miss irq", REG_IRQ_STATUS, 8'h07, 8'h00);
    expect_reg("miss buffer", REG_STATUS, 8'h04, 8'h00);
    reg_write(REG_IRQ_STATUS, 8'h0f);
    // Software answers under address and data hold
    reg_write(REG_CTRL, 8'h01);
    link_master_model_inst.start_cond();
    held_byte({OWN_ADDR, 1'b0}, 1'b0);
    reg_read(REG_DATA, d);
    reg_write(REG_CTRL, 8'h06);
    held_byte(8'h11, 1'b1);
    link_master_model_inst.stop_cond();
    reg_write(REG_CTRL, 8'h00);
    reg_read(REG_DATA, d);
    expect_reg("hold irq", REG_IRQ_STATUS, 8'h0f, 8'h0b);
    reg_write(REG_IRQ_STATUS, 8'h0f);
    // Device sends, master acknowledges once and then refuses
    reg_write(REG_DATA, 8'ha5);
    link_master_model_inst.start_cond();
    link_master_model_inst.send_byte({OWN_ADDR, 1'b1}, nack);
    check("read address ack", {7'h0, nack}, 8'h00);
    expect_reg("read request", REG_STATUS, 8'h10, 8'h10);
    link_master_model_inst.get_byte(1'b0, d);
    check("tx byte", d, 8'ha5);
    expect_reg("result ack", REG_STATUS, 8'h01, 8'h00);
    link_master_model_inst.get_byte(1'b1, d);
    check("tx repeat", d, 8'ha5);
    expect_reg("result nack", REG_STATUS, 8'h01, 8'h01);
    expect_reg("nack irq", REG_IRQ_STATUS, 8'h04, 8'h04);
    link_master_model_inst.stop_cond();
    check("clock stalls", link_master_model_inst.stalls[7:0], 8'h00);
    close_out();
  end
endmodule : testbench
